//--- mqp_dev.sv
// queue pointer registers of the device end
`timescale 1ns/100ps
`default_nettype none
`include "mqp_regs.svh"
module mqp_dev
    import mqp_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register link
    mqp_link_if.dev          link,
    // advance strobes: in free bottom, in post top, out free top
    input  wire logic [2:0]  advance,
    // pointer state towards the queue engine
    output logic [11:0]      queue_base_address,
    output logic [2:0]       depth_select,
    output mqp_offs_t        pointer_offsets
);

    // ****************************************************
    // state and helper signals
    // ****************************************************
    // the whole register file is one packed struct, so reset, next
    // state and the register itself each stay in one place
    mqp_dev_state_t s_r;
    mqp_dev_state_t s_nxt;
    // combinational helpers, none of them stored
    logic [17:0]    wrap_mask;
    logic [2:0]     adv_slot [3];
    logic [5:0]     hit;
    logic [31:0]    rd_val;

    // ****************************************************
    // queue geometry
    // ****************************************************
    // only three pointers move under device control; the other three
    // belong to the host and are merely stored and returned here
    // the strobes come from the queue engine, one per moving pointer
    // slots the device itself advances
    assign adv_slot[0] = MQP_IN_FREE_BOT;
    assign adv_slot[1] = MQP_IN_POST_TOP;
    assign adv_slot[2] = MQP_OUT_FREE_TOP;

    // all queues share one size, so a single mask serves every pointer;
    // a reserved code is a software error, and the largest size keeps
    // the pointer from wrapping short of any legal queue end
    // word mask of one queue; reserved codes behave as the largest size
    always_comb
    begin
        case (s_r.depth)
            `MQP_DEPTH_256: wrap_mask = `MQP_MASK_256;
            `MQP_DEPTH_1K:  wrap_mask = `MQP_MASK_1K;
            `MQP_DEPTH_4K:  wrap_mask = `MQP_MASK_4K;
            `MQP_DEPTH_16K: wrap_mask = `MQP_MASK_16K;
            default:        wrap_mask = `MQP_MASK_64K;
        endcase
    end

    // ****************************************************
    // register decode and read path
    // ****************************************************
    // the link carries byte offsets; a misaligned or unknown offset
    // hits no slot, so it reads zero and its write is dropped
    // only whole words are mapped; there is no byte access
    // address decode, one bit per pointer slot
    always_comb
    begin
        // nothing hits unless the offset matches a slot exactly
        hit = 6'h00;
        case (link.addr)
            `MQP_OFS_IN_FREE_TOP:  hit[MQP_IN_FREE_TOP]  = 1'b1;
            `MQP_OFS_IN_FREE_BOT:  hit[MQP_IN_FREE_BOT]  = 1'b1;
            `MQP_OFS_IN_POST_TOP:  hit[MQP_IN_POST_TOP]  = 1'b1;
            `MQP_OFS_IN_POST_BOT:  hit[MQP_IN_POST_BOT]  = 1'b1;
            `MQP_OFS_OUT_FREE_BOT: hit[MQP_OUT_FREE_BOT] = 1'b1;
            `MQP_OFS_OUT_FREE_TOP: hit[MQP_OUT_FREE_TOP] = 1'b1;
            default:               hit = 6'h00;
        endcase
    end

    // the marker sets the two reserved low bits, which no stored pointer
    // ever has, so software cannot mistake it for a real offset
    // with the option clear the plain pointer value is returned
    // read mux; a bottom pointer equal to its top reads as empty marker
    always_comb
    begin
        // unmapped offsets read as zero
        rd_val = 32'h00000000;
        case (link.addr)
            // config word: base, depth and the bottom-read option
            `MQP_OFS_CFG:
            begin
                rd_val[`MQP_BASE_HI:`MQP_BASE_LO]   = s_r.base;
                rd_val[`MQP_DEPTH_HI:`MQP_DEPTH_LO] = s_r.depth;
                rd_val[`MQP_BOT_RD_BIT]             = s_r.bot_rd;
            end
            default:
            begin
                for (int i = 0; i < 6; i++)
                begin
                    if (hit[i])
                    begin
                        rd_val = {s_r.base, s_r.off[i], 2'b00};
                    end
                end
            end
        endcase
        // each bottom slot is compared with the top slot of its own queue
        if (s_r.bot_rd)
        begin
            if ((hit[MQP_IN_FREE_BOT]
                 && s_r.off[MQP_IN_FREE_BOT] == s_r.off[MQP_IN_FREE_TOP])
             || (hit[MQP_IN_POST_BOT]
                 && s_r.off[MQP_IN_POST_BOT] == s_r.off[MQP_IN_POST_TOP])
             || (hit[MQP_OUT_FREE_BOT]
                 && s_r.off[MQP_OUT_FREE_BOT] == s_r.off[MQP_OUT_FREE_TOP]))
            begin
                rd_val = `MQP_EMPTY_READ;
            end
        end
    end

    // ****************************************************
    // next state
    // ****************************************************
    // the host wins a collision because a reseed by software must not
    // be undone by a stray advance in the same cycle; the lost advance
    // is the queue engine's to repeat
    // next state: host writes win over a same-cycle advance
    always_comb
    begin
        // ack clears; every other field holds unless an access or an advance changes it
        s_nxt     = s_r;
        s_nxt.ack = 1'b0;
        // device advance by one entry, wrapping inside the queue
        // bits above the mask are kept, so a queue placed at an offset
        // inside the block stays within its own window
        for (int k = 0; k < 3; k++)
        begin
            if (advance[k])
            begin
                s_nxt.off[adv_slot[k]] =
                    (s_r.off[adv_slot[k]] & ~wrap_mask)
                    | ((s_r.off[adv_slot[k]] + 18'h00001) & wrap_mask);
            end
        end
        // ack and read data rise together on the take edge, one cycle after req rises;
        // read data is the value before any advance of that same edge
        // one answer per request; ack low again before the next is taken
        if (link.req && !s_r.ack)
        begin
            s_nxt.ack   = 1'b1;
            // a write answers with zero read data
            s_nxt.rdata = link.wr ? 32'h00000000 : rd_val;
            if (link.wr)
            begin
                if (link.addr == `MQP_OFS_CFG)
                begin
                    s_nxt.base   = link.wdata[`MQP_BASE_HI:`MQP_BASE_LO];
                    s_nxt.depth  = link.wdata[`MQP_DEPTH_HI:`MQP_DEPTH_LO];
                    s_nxt.bot_rd = link.wdata[`MQP_BOT_RD_BIT];
                end
                // only the offset field is stored; base bits are dropped
                // the reserved low bits go too, keeping words aligned
                for (int i = 0; i < 6; i++)
                begin
                    if (hit[i])
                    begin
                        s_nxt.off[i] = link.wdata[`MQP_OFF_HI:`MQP_OFF_LO];
                    end
                end
            end
        end
    end

    // ****************************************************
    // registers and outputs
    // ****************************************************
    // every field clears on the global reset; the queue engine then
    // sees zero base and offsets until software configures the block
    // the asynchronous branch loads constants only
    // state register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r.base   <= `MQP_RST_BASE;
            s_r.depth  <= `MQP_RST_DEPTH;
            s_r.bot_rd <= 1'b0;
            s_r.off    <= {6{`MQP_RST_OFF}};
            s_r.ack    <= 1'b0;
            s_r.rdata  <= 32'h00000000;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flip-flops, so no decode glitch reaches
    // the queue engine
    assign link.ack           = s_r.ack;
    assign link.rdata         = s_r.rdata;
    assign queue_base_address = s_r.base;
    assign depth_select       = s_r.depth;
    assign pointer_offsets    = s_r.off;

endmodule // mqp_dev
`default_nettype wire

//--- mqp_regs.svh
// register offsets, field positions and reset values of the queue pointers
`ifndef MQP_REGS_SVH
`define MQP_REGS_SVH

// ****************************************************
// device register offsets
// ****************************************************
`define MQP_OFS_CFG         12'h200
`define MQP_OFS_IN_FREE_TOP 12'h204
`define MQP_OFS_IN_FREE_BOT 12'h208
`define MQP_OFS_IN_POST_TOP 12'h20c
`define MQP_OFS_IN_POST_BOT 12'h210
`define MQP_OFS_OUT_FREE_TOP 12'h214
`define MQP_OFS_OUT_FREE_BOT 12'h218

// ****************************************************
// field positions and reset values
// ****************************************************
`define MQP_BASE_HI         31
`define MQP_BASE_LO         20
`define MQP_OFF_HI          19
`define MQP_OFF_LO          2
`define MQP_DEPTH_HI        6
`define MQP_DEPTH_LO        4
`define MQP_BOT_RD_BIT      1
`define MQP_RST_BASE        12'h000
`define MQP_RST_DEPTH       3'h0
`define MQP_RST_OFF         18'h00000
`define MQP_EMPTY_READ      32'hffffffff

// depth codes and word masks
`define MQP_DEPTH_256       3'h0
`define MQP_DEPTH_1K        3'h1
`define MQP_DEPTH_4K        3'h2
`define MQP_DEPTH_16K       3'h3
`define MQP_MASK_256        18'h000ff
`define MQP_MASK_1K         18'h003ff
`define MQP_MASK_4K         18'h00fff
`define MQP_MASK_16K        18'h03fff
`define MQP_MASK_64K        18'h0ffff

// ****************************************************
// controller register offsets on apb
// ****************************************************
`define MQP_H_ADDR          12'h000
`define MQP_H_WDATA         12'h004
`define MQP_H_CTRL          12'h008
`define MQP_H_STATUS        12'h00c
`define MQP_H_RDATA         12'h010
`define MQP_H_GO_BIT        0
`define MQP_H_WR_BIT        1
`define MQP_H_BUSY_BIT      0
`define MQP_H_DONE_BIT      1

`endif

//--- mqp_pkg.sv
// types shared by the queue pointer device and its controller
package mqp_pkg;

    // pointer slots, in register order except the out free pair, whose top and bottom are swapped
    typedef enum logic [2:0] {
        MQP_IN_FREE_TOP,
        MQP_IN_FREE_BOT,
        MQP_IN_POST_TOP,
        MQP_IN_POST_BOT,
        MQP_OUT_FREE_BOT,
        MQP_OUT_FREE_TOP
    } mqp_slot_t;

    typedef logic [5:0][17:0] mqp_offs_t;

    // device state
    typedef struct packed {
        logic [11:0] base;
        logic [2:0]  depth;
        logic        bot_rd;
        mqp_offs_t   off;
        logic        ack;
        logic [31:0] rdata;
    } mqp_dev_state_t;

    typedef enum logic {MQP_H_IDLE, MQP_H_WAIT} mqp_hstate_t;

    // controller state
    typedef struct packed {
        mqp_hstate_t fsm;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        done;
        logic [31:0] rdata;
    } mqp_host_state_t;

endpackage

//--- mqp_link_if.sv
// register access link between the controller and the pointer device
`timescale 1ns/100ps
`default_nettype none
interface mqp_link_if;
    logic        req;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;

    modport dev  (input req, wr, addr, wdata, output rdata, ack);
    modport host (output req, wr, addr, wdata, input rdata, ack);
endinterface
`default_nettype wire

//--- mqp_host.sv
// controller end: apb registers drive one link access at a time
`timescale 1ns/100ps
`default_nettype none
`include "mqp_regs.svh"
module mqp_host
    import mqp_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // register link
    mqp_link_if.host         link
);

    mqp_host_state_t s_r;
    mqp_host_state_t s_nxt;
    logic            acc;
    logic            mapped;

    // zero-wait slave: every access completes in its first access cycle
    assign acc    = psel && penable;
    assign pready = 1'b1;
    assign mapped = (paddr == `MQP_H_ADDR) || (paddr == `MQP_H_WDATA)
                 || (paddr == `MQP_H_CTRL) || (paddr == `MQP_H_STATUS)
                 || (paddr == `MQP_H_RDATA);
    assign pslverr = acc && !mapped;

    // read mux
    always_comb
    begin
        prdata = 32'h00000000;
        case (paddr)
            `MQP_H_ADDR:   prdata[11:0] = s_r.addr;
            `MQP_H_WDATA:  prdata = s_r.wdata;
            `MQP_H_STATUS:
            begin
                prdata[`MQP_H_BUSY_BIT] = (s_r.fsm == MQP_H_WAIT);
                prdata[`MQP_H_DONE_BIT] = s_r.done;
            end
            `MQP_H_RDATA:  prdata = s_r.rdata;
            default:       prdata = 32'h00000000;
        endcase
    end

    // next state
    always_comb
    begin
        s_nxt = s_r;
        case (s_r.fsm)
            MQP_H_IDLE:
            begin
                if (acc && pwrite)
                begin
                    case (paddr)
                        `MQP_H_ADDR:  s_nxt.addr  = pwdata[11:0];
                        `MQP_H_WDATA: s_nxt.wdata = pwdata;
                        `MQP_H_CTRL:
                        begin
                            if (pwdata[`MQP_H_GO_BIT])
                            begin
                                s_nxt.wr   = pwdata[`MQP_H_WR_BIT];
                                s_nxt.done = 1'b0;
                                s_nxt.fsm  = MQP_H_WAIT;
                            end
                        end
                        default: s_nxt.fsm = MQP_H_IDLE;
                    endcase
                end
            end
            MQP_H_WAIT:
            begin
                // writes to any register are ignored while busy
                if (link.ack)
                begin
                    s_nxt.rdata = link.rdata;
                    s_nxt.done  = 1'b1;
                    s_nxt.fsm   = MQP_H_IDLE;
                end
            end
            default: s_nxt.fsm = MQP_H_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r.fsm   <= MQP_H_IDLE;
            s_r.addr  <= 12'h000;
            s_r.wdata <= 32'h00000000;
            s_r.wr    <= 1'b0;
            s_r.done  <= 1'b0;
            s_r.rdata <= 32'h00000000;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // link outputs hold steady for the whole wait
    assign link.req   = (s_r.fsm == MQP_H_WAIT);
    assign link.wr    = s_r.wr;
    assign link.addr  = s_r.addr;
    assign link.wdata = s_r.wdata;

endmodule // mqp_host
`default_nettype wire

//--- mqp_assertions.sv
// link protocol and readback checks for the queue pointer link
`timescale 1ns/100ps
`default_nettype none
`include "mqp_regs.svh"
module mqp_assertions (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // link signals
    input wire logic        req,
    input wire logic        wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [11:0] base_r;
    logic [2:0]  depth_r;
    logic        bot_r;
    logic        ptr_rd;
    logic        cfg_rd;

    // shadow of the config word, updated at the ack of its write
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            {base_r, depth_r, bot_r} <= '0;
        else if (ack && wr && addr == `MQP_OFS_CFG)
            {base_r, depth_r, bot_r} <= {wdata[31:20], wdata[6:4], wdata[1]};

    // answered reads of pointer slots and of the config word
    assign ptr_rd = ack && !wr && addr >= 12'h204 && addr <= 12'h218
                    && addr[1:0] == 2'h0;
    assign cfg_rd = ack && !wr && addr == `MQP_OFS_CFG;

    // ****************************************************
    // properties
    // ****************************************************
    a_ack_after_take: assert property (req && !ack |=> ack)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_with_req: assert property (ack |-> req)
        else $error("ack without request");
    a_req_released: assert property (ack |=> !req)
        else $error("request held after ack");
    a_req_steady: assert property (req && !ack |=> $stable({wr, addr, wdata}))
        else $error("request changed before ack");
    a_base_readback: assert property (
        ptr_rd && rdata != `MQP_EMPTY_READ |-> rdata[31:20] == base_r)
        else $error("pointer read lost base bits");
    a_no_marker_off: assert property (ptr_rd && !bot_r |-> rdata[1:0] == 2'h0)
        else $error("low bits or marker with option clear");
    a_cfg_readback: assert property (
        cfg_rd |-> rdata == {base_r, 13'h0, depth_r, 2'h0, bot_r, 1'b0})
        else $error("config readback wrong");

    cover property (ptr_rd && rdata == `MQP_EMPTY_READ);
    cover property (ack && wr);
    cover property (cfg_rd);
endmodule // mqp_assertions
`default_nettype wire

//--- testbench.sv
// self-checking bench: controller and device joined over the link
`timescale 1ns/100ps
`default_nettype none
`include "mqp_regs.svh"
module testbench;
    logic        ref_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  advance;
    logic [31:0] rd;
    logic        err;
    logic [11:0] qba;
    logic [2:0]  dsel;
    logic [5:0][17:0] poffs;
    int          n_fail;
    int          total_checks;
    // address, write data, expected readback
    logic [75:0] rows [8] = '{
        {12'h200, 32'habcfff1d, 32'habc00010},
        {12'h204, 32'hfff1234f, 32'habc1234c},
        {12'h208, 32'h00012ff8, 32'habc12ff8},
        {12'h20c, 32'h12345678, 32'habc45678},
        {12'h210, 32'h000ffffc, 32'habcffffc},
        {12'h214, 32'h00000100, 32'habc00100},
        {12'h218, 32'h00000004, 32'habc00004},
        {12'h21c, 32'hffffffff, 32'h00000000}};

    mqp_link_if lnk ();
    mqp_dev i_mqp_dev (.ref_clk(ref_clk), .rst(rst), .link(lnk),
        .advance(advance), .queue_base_address(qba), .depth_select(dsel),
        .pointer_offsets(poffs));
    mqp_host i_mqp_host (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lnk));
    mqp_assertions i_mqp_assertions (.ref_clk(ref_clk), .rst(rst),
        .req(lnk.req), .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata),
        .rdata(lnk.rdata), .ack(lnk.ack));

    // ****************************************************
    // tasks
    // ****************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; entered after an edge so psel never toggles twice
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // device access: address, data, go, then poll until done
    task automatic dacc(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int k;
        apb(1'b1, `MQP_H_ADDR, {20'h0, a});
        apb(1'b1, `MQP_H_WDATA, d);
        apb(1'b1, `MQP_H_CTRL, {30'h0, w, 1'b1});
        k = 0;
        do
        begin
            apb(1'b0, `MQP_H_STATUS, 32'h0);
            k++;
        end
        while (rd[`MQP_H_DONE_BIT] !== 1'b1 && k < 20);
        if (k == 20)
            n_fail++;
        apb(1'b0, `MQP_H_RDATA, 32'h0);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        dacc(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // one-cycle advance strobe
    task automatic adv(input int i);
        @(posedge ref_clk);
        advance <= 3'(1 << i);
        @(posedge ref_clk);
        advance <= 3'h0;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // watchdog: the run needs well under a tenth of this
    initial
    begin
        #100000;
        n_fail++;
        give_verdict();
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        advance = 3'h0;
        n_fail = 0;
        total_checks = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            dacc(1'b1, rows[i][75:64], rows[i][63:32]);
            rdc(rows[i][75:64], rows[i][31:0]);
        end
        chk({20'h0, qba}, 32'h00000abc);
        chk({29'h0, dsel}, 32'h00000001);
        chk({14'h0, poffs[1]}, 32'h00004bfe);
        $display("table done");
        // depth code 1 gives 1K entries, so the low ten word bits wrap
        adv(0);
        rdc(12'h208, 32'habc12ffc);
        adv(0);
        rdc(12'h208, 32'habc12000);
        adv(1);
        rdc(12'h20c, 32'habc4567c);
        adv(2);
        rdc(12'h214, 32'habc00104);
        chk({14'h0, poffs[5]}, 32'h00000041);
        $display("advance done");
        dacc(1'b1, 12'h200, 32'habc00012);
        dacc(1'b1, 12'h218, 32'h00000104);
        rdc(12'h218, 32'hffffffff);
        rdc(12'h210, 32'habcffffc);
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("marker done");
        // largest and smallest sizes, each seeded one entry before its end
        dacc(1'b1, 12'h200, 32'habc00040);
        dacc(1'b1, 12'h20c, 32'h0003fffc);
        adv(1);
        rdc(12'h20c, 32'habc00000);
        chk({29'h0, dsel}, 32'h00000004);
        dacc(1'b1, 12'h200, 32'habc00000);
        dacc(1'b1, 12'h20c, 32'h000043fc);
        adv(1);
        rdc(12'h20c, 32'habc04000);
        $display("depth done");
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rdc(12'h204, 32'h0);
        rdc(12'h200, 32'h0);
        $display("reset done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
